/* wsv_pkg.sv */
// shared constants and types of the weld slope, valve and stepper block
package wsv_pkg;

  // ==========================================================================
  // slope and stepper mode codes
  localparam logic [1:0] SLOPE_NONE = 2'h0;
  localparam logic [1:0] SLOPE_UP = 2'h1;
  localparam logic [1:0] SLOPE_DOWN = 2'h2;
  localparam logic [1:0] STP_OFF = 2'h0;
  localparam logic [1:0] STP_MULTI = 2'h1;
  localparam logic [1:0] STP_SINGLE = 2'h2;

  // ==========================================================================
  // widths and sizes
  localparam int PCT_W = 7;
  localparam int CNT_W = 7;
  localparam int SCNT_W = 14;
  localparam int IDX_W = 6;
  localparam int SEL_W = 3;
  localparam int STEPPERS = 5;
  localparam int STEPS_PER = 10;
  localparam int TOTAL_STEPS = 50;
  localparam int QUARTER_SH = 2;

  // ==========================================================================
  // value limits
  localparam logic [CNT_W-1:0] SLOPE_MIN = 7'h01;
  localparam logic [CNT_W-1:0] SLOPE_MAX = 7'h63;
  localparam logic [SCNT_W-1:0] STEP_CNT_MAX = 14'h270F;

  // ==========================================================================
  // timing: one line cycle
  localparam int CLK_HZ = 250_000_000;
  localparam int LINE_HZ = 60;
  localparam int LINE_DIV = CLK_HZ / LINE_HZ;

  // ==========================================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_UP = 4'h2,
    ST_WELD = 4'h4,
    ST_DOWN = 4'h8
  } wsv_state_t;

endpackage : wsv_pkg

/* wsv_ramp.sv */
// slope ramp level for one line cycle of an up- or downslope
`timescale 1ns/1ps
module wsv_ramp #(
  parameter int W = 7
) (
  input wire logic [W-1:0] from_lvl,
  input wire logic [W-1:0] to_lvl,
  input wire logic [W-1:0] cnt,
  input wire logic [W-1:0] k,
  output logic [W-1:0] level
);

  // ==========================================================================
  // equal integer steps; once k reaches cnt the level lands exactly on the target
  logic signed [W+1:0] diff;
  logic signed [W+1:0] step;
  logic signed [2*W+3:0] prod;
  logic signed [2*W+3:0] sum;
  logic [W-1:0] cnt_nz;

  assign cnt_nz = (cnt == '0) ? W'(1) : cnt;
  assign diff = $signed({2'h0, to_lvl}) - $signed({2'h0, from_lvl});
  assign step = diff / $signed({2'h0, cnt_nz});
  assign prod = step * $signed({(W+4)'(0), k});
  assign sum = $signed({(W+4)'(0), from_lvl}) + prod;
  assign level = (k >= cnt_nz) ? to_lvl : sum[W-1:0];

endmodule : wsv_ramp

/* wsv_top.sv */
// weld slope sequencer, valve outputs and weld steppers
// How it works
// RQ1 - slope count and weld count are separate; slope cycles add to weld cycles
// RQ2 - slope mode 00 welds at programmed current from the first cycle
// RQ3 - slope mode 01 runs upslope cycles right before weld cycles
// RQ4 - repeat or pulsation: upslope only before the first impulse
// RQ5 - seam operation: upslope only on the first initiation
// RQ6 - single schedule upslope starts at a quarter, rises to programmed current
// RQ7 - chained upslope starts at own current, ramps to next schedule current
// RQ8 - slope mode 02 runs downslope right after weld cycles
// RQ9 - repeat or pulsation: downslope only after the last impulse
// RQ10 - seam operation: downslope when the last initiation is released
// RQ11 - single schedule downslope falls from programmed current to a quarter
// RQ12 - chained downslope ends on the next schedule current
// RQ13 - valve code bits 0, 1, 2 drive valves one, two, three
// RQ14 - program mode shows the valve code, all valves off
// RQ15 - five steppers, ten steps each, counts 0000 to 9999
// RQ16 - a new step selects another schedule for later welds
// RQ17 - alarm output when the last step count runs out
// RQ18 - ended stepper restored by manual pulse or automatically
// RQ19 - stepper mode 02 uses one counter over all fifty steps
// RQ20 - count only welds made: time, current nonzero and weld switch on
// RQ21 - any stepper works as a plain weld down-counter
// RQ22 - slope counts 01 to 99 line cycles are accepted
// RQ23 - ramp level updated once per line cycle by integer step
`timescale 1ns/1ps
module wsv_top
  import wsv_pkg::*;
#(
  parameter int LINE_CYCLE_CLKS = wsv_pkg::LINE_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic seq_start,
  input wire logic seq_active,
  input wire logic program_mode,
  input wire logic [1:0] slope_mode,
  input wire logic [wsv_pkg::CNT_W-1:0] slope_count,
  input wire logic [wsv_pkg::CNT_W-1:0] weld_count,
  input wire logic [wsv_pkg::PCT_W-1:0] pct_current,
  input wire logic [wsv_pkg::PCT_W-1:0] next_pct_current,
  input wire logic sched_chained,
  input wire logic first_impulse,
  input wire logic last_impulse,
  input wire logic first_initiation,
  input wire logic seam_mode,
  input wire logic init_held,
  input wire logic weld_switch,
  input wire logic [2:0] valve_code,
  input wire logic [1:0] stepper_mode,
  input wire logic [wsv_pkg::SEL_W-1:0] stepper_sel,
  input wire logic step_tbl_wr,
  input wire logic [wsv_pkg::IDX_W-1:0] step_tbl_addr,
  input wire logic [wsv_pkg::SCNT_W-1:0] step_tbl_data,
  input wire logic last_step_wr,
  input wire logic [wsv_pkg::IDX_W-1:0] last_step_data,
  input wire logic stepper_restore,
  input wire logic auto_restore,
  input wire logic alarm_enable,
  output logic [wsv_pkg::PCT_W-1:0] weld_current,
  output logic heat_on,
  output logic seq_done,
  output logic valve_one_output,
  output logic valve_two_output,
  output logic valve_three_output,
  output logic [2:0] valve_ind,
  output logic [wsv_pkg::IDX_W-1:0] step_index,
  output logic [wsv_pkg::SCNT_W-1:0] step_remaining,
  output logic stepper_alarm
);
  import wsv_pkg::*;

  localparam int DW = $clog2(LINE_CYCLE_CLKS + 1);

  generate
    if (LINE_CYCLE_CLKS < 1) begin : g_bad_div
      $error("line cycle divider must be at least one clock");
    end
  endgenerate

  function automatic logic [IDX_W-1:0] step_base(input logic [SEL_W-1:0] s,
                                                 input logic single);
    step_base = single ? '0 : IDX_W'(s * STEPS_PER);
  endfunction : step_base

  // ==========================================================================
  // weld switch synchroniser and line cycle divider
  logic ws_meta_reg;
  logic ws_sync_reg;
  logic [DW-1:0] div_reg;
  wire line_tick = (div_reg == DW'(LINE_CYCLE_CLKS - 1));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ws_meta_reg <= 1'b0;
      ws_sync_reg <= 1'b0;
      div_reg <= '0;
    end
    else
    begin
      ws_meta_reg <= weld_switch;
      ws_sync_reg <= ws_meta_reg;
      div_reg <= line_tick ? '0 : div_reg + DW'(1);
    end
  end

  // ==========================================================================
  // schedule values caught at initiation
  wsv_state_t state_reg;
  wsv_state_t state_next;
  logic [CNT_W-1:0] cyc_reg;
  logic [CNT_W-1:0] weld_n_reg;
  logic [CNT_W-1:0] slope_n_reg;
  logic [PCT_W-1:0] pct_reg;
  logic [PCT_W-1:0] nxt_reg;
  logic chain_reg;
  logic up_mode_reg;
  logic dn_mode_reg;
  logic made_reg;

  wire idle = (state_reg == ST_IDLE);
  wire take = idle && seq_start;
  wire slope_ok = (slope_count >= SLOPE_MIN) && (slope_count <= SLOPE_MAX); // see RQ22
  wire do_up = (slope_mode == SLOPE_UP) && slope_ok && first_impulse && first_initiation; // see RQ4
  wire slope_end = (cyc_reg == slope_n_reg - CNT_W'(1));
  wire weld_end = (weld_n_reg == '0) || (cyc_reg == weld_n_reg - CNT_W'(1));
  wire seam_hold = seam_mode && init_held;
  wire down_ok = dn_mode_reg && last_impulse && !seam_hold; // see RQ9 see RQ10

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      weld_n_reg <= '0;
      slope_n_reg <= '0;
      pct_reg <= '0;
      nxt_reg <= '0;
      chain_reg <= 1'b0;
      up_mode_reg <= 1'b0;
      dn_mode_reg <= 1'b0;
      made_reg <= 1'b0;
    end
    else if (take)
    begin
      weld_n_reg <= weld_count; // see RQ1
      slope_n_reg <= slope_count; // see RQ1
      pct_reg <= pct_current;
      nxt_reg <= next_pct_current;
      chain_reg <= sched_chained;
      up_mode_reg <= (slope_mode == SLOPE_UP);
      dn_mode_reg <= (slope_mode == SLOPE_DOWN) && slope_ok; // see RQ8
      made_reg <= (weld_count != '0) && (pct_current != '0) && ws_sync_reg; // see RQ20
    end
  end

  // ==========================================================================
  // slope sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (seq_start)
          state_next = do_up ? ST_UP : ST_WELD; // see RQ2 see RQ3 see RQ5
      ST_UP:
        if (line_tick && slope_end)
          state_next = ST_WELD; // see RQ3
      ST_WELD:
        if (line_tick && weld_end && !seam_hold)
          state_next = down_ok ? ST_DOWN : ST_IDLE; // see RQ8
      ST_DOWN:
        if (line_tick && slope_end)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cyc_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next != state_reg)
        cyc_reg <= '0;
      else if (line_tick)
        cyc_reg <= (state_reg == ST_WELD && weld_end) ? '0 : cyc_reg + CNT_W'(1);
    end
  end

  // ==========================================================================
  // current levels
  wire [PCT_W-1:0] quarter = pct_reg >> QUARTER_SH;
  wire [PCT_W-1:0] up_from = chain_reg ? pct_reg : quarter; // see RQ6 see RQ7
  wire [PCT_W-1:0] up_to = chain_reg ? nxt_reg : pct_reg; // see RQ6 see RQ7
  wire [PCT_W-1:0] dn_to = chain_reg ? nxt_reg : quarter; // see RQ11 see RQ12
  wire [PCT_W-1:0] weld_lvl = (chain_reg && up_mode_reg) ? nxt_reg : pct_reg;
  wire in_up = (state_reg == ST_UP);
  wire [PCT_W-1:0] ramp_lvl;

  wsv_ramp #(
    .W(PCT_W)
  ) u_ramp (
    .from_lvl(in_up ? up_from : pct_reg),
    .to_lvl(in_up ? up_to : dn_to),
    .cnt(slope_n_reg),
    .k(in_up ? cyc_reg : cyc_reg + CNT_W'(1)), // see RQ23
    .level(ramp_lvl)
  );

  logic [PCT_W-1:0] cur_next;
  always_comb
  begin
    case (state_reg)
      ST_UP: cur_next = ramp_lvl;
      ST_WELD: cur_next = weld_lvl; // see RQ2
      ST_DOWN: cur_next = ramp_lvl;
      default: cur_next = '0;
    endcase
  end

  logic [PCT_W-1:0] cur_reg;
  logic heat_reg;
  logic done_reg;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cur_reg <= '0;
      heat_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      cur_reg <= cur_next; // see RQ23
      heat_reg <= !idle;
      done_reg <= !idle && (state_next == ST_IDLE);
    end
  end
  assign weld_current = cur_reg;
  assign heat_on = heat_reg;
  assign seq_done = done_reg;

  // ==========================================================================
  // valve outputs and indicators
  wire valve_on = !program_mode && seq_active; // see RQ14
  logic [2:0] valve_reg;
  logic [2:0] ind_reg;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      valve_reg <= '0;
      ind_reg <= '0;
    end
    else
    begin
      valve_reg <= valve_on ? valve_code : 3'h0; // see RQ13
      ind_reg <= valve_code; // see RQ14
    end
  end
  assign valve_one_output = valve_reg[0];
  assign valve_two_output = valve_reg[1];
  assign valve_three_output = valve_reg[2];
  assign valve_ind = ind_reg;

  // ==========================================================================
  // step count table and steppers
  logic [SCNT_W-1:0] tbl_mem [TOTAL_STEPS];
  logic [IDX_W-1:0] stp_step_reg [STEPPERS];
  logic [SCNT_W-1:0] stp_cnt_reg [STEPPERS];
  logic [IDX_W-1:0] stp_last_reg [STEPPERS];
  logic [STEPPERS-1:0] stp_end_reg;

  wire single = (stepper_mode == STP_SINGLE); // see RQ19
  wire stp_on = (stepper_mode != STP_OFF);
  wire [SEL_W-1:0] act = single ? '0 : stepper_sel;
  wire act_ok = stp_on && (act < SEL_W'(STEPPERS));
  wire tbl_ok = (step_tbl_addr < IDX_W'(TOTAL_STEPS)) && (step_tbl_data <= STEP_CNT_MAX);

  always_ff @(posedge core_clk)
  begin
    if (step_tbl_wr && tbl_ok)
      tbl_mem[step_tbl_addr] <= step_tbl_data; // see RQ15
  end

  genvar gi;
  generate
    for (gi = 0; gi < STEPPERS; gi++) begin : g_stp
      wire me = act_ok && (act == SEL_W'(gi));
      wire [IDX_W-1:0] base = step_base(SEL_W'(gi), single);
      wire cnt_ev = me && done_reg && made_reg; // see RQ20
      wire exhaust = (stp_cnt_reg[gi] <= SCNT_W'(1));
      wire at_last = (stp_step_reg[gi] == stp_last_reg[gi]);
      wire [IDX_W-1:0] nstep = stp_step_reg[gi] + IDX_W'(1);
      // a stepper ending in the same cycle as a restore stays ended
      wire ending = cnt_ev && !stp_end_reg[gi] && exhaust
        && (at_last || nstep >= IDX_W'(TOTAL_STEPS));
      wire reload = (me && stepper_restore && !ending)
        || (cnt_ev && stp_end_reg[gi] && auto_restore);

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          stp_step_reg[gi] <= step_base(SEL_W'(gi), 1'b0);
          stp_cnt_reg[gi] <= '0;
          stp_last_reg[gi] <= step_base(SEL_W'(gi), 1'b0);
          stp_end_reg[gi] <= 1'b0;
        end
        else
        begin
          if (me && last_step_wr && last_step_data < IDX_W'(TOTAL_STEPS))
            stp_last_reg[gi] <= last_step_data;
          if (reload)
          begin
            stp_step_reg[gi] <= base; // see RQ18
            stp_cnt_reg[gi] <= tbl_mem[base];
            stp_end_reg[gi] <= 1'b0;
          end
          else if (cnt_ev && !stp_end_reg[gi])
          begin
            if (!exhaust)
              stp_cnt_reg[gi] <= stp_cnt_reg[gi] - SCNT_W'(1); // see RQ21
            else if (at_last || nstep >= IDX_W'(TOTAL_STEPS))
            begin
              stp_cnt_reg[gi] <= '0;
              stp_end_reg[gi] <= 1'b1; // see RQ17
            end
            else
            begin
              stp_step_reg[gi] <= nstep; // see RQ16
              stp_cnt_reg[gi] <= tbl_mem[nstep];
            end
          end
        end
      end

      a_hold_no_weld: assert property (@(posedge core_clk) disable iff (rst)
        (done_reg && !made_reg && !stepper_restore) |=> $stable(stp_cnt_reg[gi])) // see RQ20
        else $error("stepper count moved without a weld");
    end
  endgenerate

  logic [IDX_W-1:0] sidx_reg;
  logic [SCNT_W-1:0] srem_reg;
  logic alarm_reg;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sidx_reg <= '0;
      srem_reg <= '0;
      alarm_reg <= 1'b0;
    end
    else
    begin
      sidx_reg <= act_ok ? stp_step_reg[act] : '0; // see RQ16
      srem_reg <= act_ok ? stp_cnt_reg[act] : '0;
      alarm_reg <= alarm_enable && stp_on && (|stp_end_reg); // see RQ17
    end
  end
  assign step_index = sidx_reg;
  assign step_remaining = srem_reg;
  assign stepper_alarm = alarm_reg;

  // ==========================================================================
  // assertions and cover points
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_valve_prog_off: assert property (program_mode |=> valve_reg == 3'h0) // see RQ14
    else $error("valve energised in program mode");
  a_valve_map: assert property (valve_on |=> valve_one_output == $past(valve_code[0])
    && valve_two_output == $past(valve_code[1])
    && valve_three_output == $past(valve_code[2])) // see RQ13
    else $error("valve outputs do not follow the valve code");
  a_no_slope_weld: assert property (take && slope_mode == SLOPE_NONE
    |=> state_reg == ST_WELD ##1 weld_current == pct_reg) // see RQ2
    else $error("no slope mode did not weld at full current");
  a_up_first: assert property (take && do_up |=> state_reg == ST_UP) // see RQ3
    else $error("upslope not started");
  a_up_skip: assert property (take && !(first_impulse && first_initiation)
    |=> state_reg != ST_UP) // see RQ4
    else $error("upslope repeated on later impulse or initiation");
  a_up_len: assert property (in_up && line_tick && slope_end // see RQ1
    |=> state_reg == ST_WELD ##1 weld_current == up_to)
    else $error("upslope length wrong");
  a_up_start: assert property (in_up && cyc_reg == '0 |=> weld_current == $past(up_from)) // see RQ6
    else $error("upslope start level wrong");
  a_down_after: assert property (state_reg == ST_WELD && line_tick && weld_end
    && !seam_hold && down_ok |=> state_reg == ST_DOWN) // see RQ8
    else $error("downslope did not follow weld");
  a_down_bottom: assert property (state_reg == ST_DOWN && slope_end
    |=> weld_current == $past(dn_to)) // see RQ11
    else $error("downslope bottom level wrong");

  c_upslope: cover property (in_up && line_tick && slope_end);
  c_downslope: cover property (state_reg == ST_DOWN && line_tick && slope_end);
  c_alarm: cover property ($rose(stepper_alarm));
  c_step_up: cover property (step_index != $past(step_index) && stp_on);

endmodule : wsv_top

/* wsv_load_model.sv */
// load side model: contactor, weld transformer and solenoid valves
`timescale 1ns/1ps
module wsv_load_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic log_clr,
  input wire logic heat_on,
  input wire logic [wsv_pkg::PCT_W-1:0] weld_current,
  input wire logic [2:0] valve_drive,
  output logic [2:0] valve_energised,
  output logic [wsv_pkg::PCT_W-1:0] lvl_log [0:127],
  output int lvl_n,
  output int heat_clks
);
  import wsv_pkg::*;
  // ==========================================================================
  // solenoids follow their drive
  assign valve_energised = valve_drive;
  // ==========================================================================
  // contactor fires only with heat on; each new level is logged
  always_ff @(posedge core_clk)
  begin
    if (rst || log_clr)
    begin
      lvl_n <= 0;
      heat_clks <= 0;
    end
    else if (heat_on)
    begin
      heat_clks <= heat_clks + 1;
      if (lvl_n == 0 || weld_current !== lvl_log[lvl_n-1])
      begin
        lvl_log[lvl_n] <= weld_current;
        lvl_n <= lvl_n + 1;
      end
    end
  end
endmodule : wsv_load_model

/* tb.sv */
// testbench of the weld slope, valve and stepper block
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch t=%0t %s got %0h exp %0h", $time, msg, got, exp); end end
module tb;
  import wsv_pkg::*;
  localparam int LC = 8;
  logic core_clk = 0;
  logic rst = 1;
  logic seq_start, seq_active, program_mode, sched_chained, first_impulse, last_impulse;
  logic first_initiation, seam_mode, init_held, weld_switch, step_tbl_wr, last_step_wr;
  logic stepper_restore, auto_restore, alarm_enable, log_clr, heat_on, seq_done;
  logic valve_one_output, valve_two_output, valve_three_output, stepper_alarm;
  logic [1:0] slope_mode, stepper_mode;
  logic [2:0] valve_code, stepper_sel, valve_ind, valve_energised;
  logic [CNT_W-1:0] slope_count, weld_count;
  logic [PCT_W-1:0] pct_current, next_pct_current, weld_current;
  logic [PCT_W-1:0] lvl_log [0:127];
  logic [IDX_W-1:0] step_tbl_addr, last_step_data, step_index;
  logic [SCNT_W-1:0] step_tbl_data, step_remaining;
  int lvl_n, heat_clks, checked, bad_count;
  always #2 core_clk = ~core_clk;
  wsv_top #(.LINE_CYCLE_CLKS(LC)) u_dut (.core_clk(core_clk), .rst(rst), .seq_start(seq_start),
    .seq_active(seq_active), .program_mode(program_mode), .slope_mode(slope_mode),
    .slope_count(slope_count), .weld_count(weld_count), .pct_current(pct_current),
    .next_pct_current(next_pct_current), .sched_chained(sched_chained),
    .first_impulse(first_impulse), .last_impulse(last_impulse),
    .first_initiation(first_initiation), .seam_mode(seam_mode), .init_held(init_held),
    .weld_switch(weld_switch), .valve_code(valve_code), .stepper_mode(stepper_mode),
    .stepper_sel(stepper_sel), .step_tbl_wr(step_tbl_wr), .step_tbl_addr(step_tbl_addr),
    .step_tbl_data(step_tbl_data), .last_step_wr(last_step_wr),
    .last_step_data(last_step_data), .stepper_restore(stepper_restore),
    .auto_restore(auto_restore), .alarm_enable(alarm_enable), .weld_current(weld_current),
    .heat_on(heat_on), .seq_done(seq_done), .valve_one_output(valve_one_output),
    .valve_two_output(valve_two_output), .valve_three_output(valve_three_output),
    .valve_ind(valve_ind), .step_index(step_index), .step_remaining(step_remaining),
    .stepper_alarm(stepper_alarm));
  wsv_load_model u_load (.core_clk(core_clk), .rst(rst), .log_clr(log_clr),
    .heat_on(heat_on), .weld_current(weld_current),
    .valve_drive({valve_three_output, valve_two_output, valve_one_output}),
    .valve_energised(valve_energised), .lvl_log(lvl_log), .lvl_n(lvl_n),
    .heat_clks(heat_clks));
  // ==========================================================================
  // verdict and end of run
  task final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // ==========================================================================
  // one weld sequence; expected levels built from slope settings
  task automatic run_seq(input int md, s, w, pct, nxt, input bit ch, fi, li, input int hold);
    int exp_q[$];
    int fr, to, st, n, k, t;
    @(negedge core_clk);
    slope_mode = 2'(md);
    slope_count = 7'(s);
    weld_count = 7'(w);
    pct_current = 7'(pct);
    next_pct_current = 7'(nxt);
    sched_chained = ch;
    first_impulse = fi;
    first_initiation = fi;
    last_impulse = li;
    log_clr = 1;
    seq_start = 1;
    @(negedge core_clk);
    log_clr = 0;
    seq_start = 0;
    if (s < 1 || s > 99)
      md = 0;
    n = w;
    if (md == 1 && fi)
    begin
      fr = ch ? pct : pct / 4;
      to = ch ? nxt : pct;
      st = (to - fr) / s;
      for (k = 0; k < s; k++)
        if (exp_q.size() == 0 || exp_q[$] != fr + st * k) exp_q.push_back(fr + st * k);
      if (exp_q[$] != to) exp_q.push_back(to);
      n += s;
    end
    else
      exp_q.push_back(pct);
    if (md == 2 && li)
    begin
      to = ch ? nxt : pct / 4;
      st = (to - pct) / s;
      for (k = 1; k <= s; k++)
        exp_q.push_back(k == s ? to : pct + st * k);
      n += s;
    end
    if (hold > 0)
    begin
      repeat (hold) @(negedge core_clk);
      `CHK(weld_current, 7'(pct), "seam weld level")
      init_held = 0;
    end
    t = 0;
    while (seq_done !== 1'b1 && t < 20000)
    begin
      @(negedge core_clk);
      t++;
    end
    `CHK(seq_done, 1'b1, "sequence end")
    repeat (3) @(negedge core_clk);
    `CHK(lvl_n, exp_q.size(), "level count")
    for (k = 0; k < exp_q.size() && k < 128; k++)
      `CHK(lvl_log[k], 7'(exp_q[k]), "level")
    if (hold == 0)
      `CHK(heat_clks >= (n-1)*LC && heat_clks <= n*LC+1, 1'b1, "heat time")
  endtask : run_seq
  task t_slope_none;
    run_seq(0, 5, 6, 50, 0, 0, 1, 1, 0);
    run_seq(1, 0, 4, 40, 0, 0, 1, 1, 0);
  endtask : t_slope_none
  task t_upslope;
    run_seq(1, 9, 26, 60, 0, 0, 1, 1, 0);
    run_seq(1, 15, 20, 30, 75, 1, 1, 1, 0);
    run_seq(1, 9, 5, 60, 0, 0, 0, 1, 0);
    run_seq(1, 99, 2, 100, 0, 0, 1, 1, 0);
  endtask : t_upslope
  task t_downslope;
    run_seq(2, 10, 25, 80, 0, 0, 1, 1, 0);
    run_seq(2, 15, 20, 75, 15, 1, 1, 1, 0);
    run_seq(2, 10, 5, 80, 0, 0, 1, 0, 0);
    run_seq(2, 1, 3, 40, 0, 0, 1, 1, 0);
  endtask : t_downslope
  task t_seam;
    seam_mode = 1;
    init_held = 1;
    run_seq(2, 4, 3, 64, 0, 0, 1, 1, 11 * LC);
    seam_mode = 0;
  endtask : t_seam
  task t_valves;
    int c;
    seq_active = 1;
    for (c = 0; c < 8; c++)
    begin
      @(negedge core_clk);
      valve_code = 3'(c);
      program_mode = 0;
      repeat (2) @(negedge core_clk);
      `CHK(valve_energised, 3'(c), "valves")
      program_mode = 1;
      repeat (2) @(negedge core_clk);
      `CHK(valve_energised, 3'h0, "program valves")
      `CHK(valve_ind, 3'(c), "valve indicators")
    end
    program_mode = 0;
    seq_active = 0;
  endtask : t_valves
  // ==========================================================================
  // stepper helpers
  task ctl(input int op, a, d);
    @(negedge core_clk);
    step_tbl_addr = 6'(a);
    step_tbl_data = 14'(d);
    last_step_data = 6'(a);
    step_tbl_wr = (op == 0);
    last_step_wr = (op == 1);
    stepper_restore = (op == 2);
    @(negedge core_clk);
    step_tbl_wr = 0;
    last_step_wr = 0;
    stepper_restore = 0;
    repeat (2) @(negedge core_clk);
  endtask : ctl
  task weld(input int pct);
    run_seq(0, 1, 1, pct, 0, 0, 1, 1, 0);
  endtask : weld
  task t_stepper;
    stepper_mode = 1;
    stepper_sel = 1;
    ctl(0, 10, 2);
    ctl(0, 11, 1);
    ctl(0, 10, 10000);
    ctl(2, 0, 0);
    ctl(1, 11, 0);
    `CHK({step_index, step_remaining}, {6'h0a, 14'h0002}, "first step")
    weld_switch = 0;
    repeat (4) @(negedge core_clk);
    weld(20);
    weld_switch = 1;
    repeat (4) @(negedge core_clk);
    weld(0);
    `CHK(step_remaining, 14'h0002, "no weld made")
    weld(20);
    `CHK(step_remaining, 14'h0001, "count down")
    weld(20);
    `CHK({step_index, step_remaining}, {6'h0b, 14'h0001}, "next step")
    weld(20);
    `CHK({stepper_alarm, step_remaining}, {1'b1, 14'h0000}, "ended")
    weld(20);
    `CHK({stepper_alarm, step_remaining}, {1'b1, 14'h0000}, "held ended")
    alarm_enable = 0;
    repeat (2) @(negedge core_clk);
    `CHK(stepper_alarm, 1'b0, "alarm disabled")
    alarm_enable = 1;
    ctl(2, 0, 0);
    `CHK({stepper_alarm, step_index}, {1'b0, 6'h0a}, "manual restore")
    auto_restore = 1;
    repeat (4) weld(20);
    `CHK({stepper_alarm, step_index}, {1'b0, 6'h0a}, "auto restore")
    auto_restore = 0;
  endtask : t_stepper
  task t_single;
    stepper_mode = 2;
    stepper_sel = 3;
    ctl(0, 0, 1);
    ctl(0, 1, 3);
    ctl(2, 0, 0);
    ctl(1, 45, 0);
    `CHK({step_index, step_remaining}, {6'h00, 14'h0001}, "single first")
    weld(20);
    `CHK({step_index, step_remaining}, {6'h01, 14'h0003}, "single next")
  endtask : t_single
  // ==========================================================================
  // main sequence and watchdog
  initial
  begin
    {seq_start, seq_active, program_mode, sched_chained, first_impulse, last_impulse} = '0;
    {first_initiation, seam_mode, init_held, step_tbl_wr, last_step_wr} = '0;
    {stepper_restore, auto_restore, log_clr, slope_mode, stepper_mode} = '0;
    {valve_code, stepper_sel, slope_count, weld_count, pct_current} = '0;
    {next_pct_current, step_tbl_addr, step_tbl_data, last_step_data} = '0;
    weld_switch = 1;
    alarm_enable = 1;
    checked = 0;
    bad_count = 0;
    repeat (4) @(negedge core_clk);
    rst = 0;
    @(negedge core_clk);
    `CHK({weld_current, heat_on, step_index, stepper_alarm}, 15'h0000, "reset state")
    t_slope_none();
    t_upslope();
    t_downslope();
    t_seam();
    t_valves();
    t_stepper();
    t_single();
    final_report();
  end
  initial
  begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    final_report();
  end
endmodule : tb
